// file: core/opsq_pkg.sv
// opsq_pkg: offsets, reset values, fields and oscillator counts for the
// output driver power sequencer.
// assumes the oscillator tick arrives as a pin level at about 8.2 MHz.
package opsq_pkg;
	// register numbers within a page
	localparam logic [7:0] ADDR_PAGE = 8'h00;
	localparam logic [7:0] ADDR_SPK = 8'h20;
	localparam logic [7:0] ADDR_POP = 8'h21;
	localparam logic [7:0] ADDR_RAMP = 8'h22;
	localparam logic [7:0] PAGE_ONE = 8'h01;
	// reset values
	localparam logic [7:0] RST_PAGE = 8'h00;
	localparam logic [7:0] RST_SPK = 8'h06;
	localparam logic [7:0] RST_POP = 8'h3e;
	localparam logic [7:0] RST_RAMP = 8'h00;
	// field positions
	localparam int SPK_EN_BIT = 7;
	localparam int SPK_SHORT_BIT = 0;
	localparam int POP_ORDER_BIT = 7;
	localparam int POP_PWRON_LSB = 3;
	localparam int POP_STEP_LSB = 1;
	localparam int POP_CM_BIT = 0;
	localparam int RAMP_WAIT_LSB = 4;
	// oscillator counts
	localparam int CW = 26;
	localparam real OSC_MHZ = 8.2;
	function automatic logic [CW-1:0] us2osc(input real us);
		return CW'(int'(us * OSC_MHZ));
	endfunction
	// power-on times; reserved codes fall back to the longest time
	localparam logic [CW-1:0] PWRON_CYC [16] = '{
		us2osc(0.0), us2osc(15.3), us2osc(15.3), us2osc(1530.0),
		us2osc(15300.0), us2osc(76200.0), us2osc(153000.0),
		us2osc(304000.0), us2osc(610000.0), us2osc(1220000.0),
		us2osc(3040000.0), us2osc(6100000.0), us2osc(6100000.0),
		us2osc(6100000.0), us2osc(6100000.0), us2osc(6100000.0)};
	localparam logic [CW-1:0] STEP_CYC [4] = '{
		us2osc(0.0), us2osc(980.0), us2osc(1950.0), us2osc(3900.0)};
	localparam logic [CW-1:0] WAIT_CYC [8] = '{
		us2osc(0.0), us2osc(3040.0), us2osc(7620.0), us2osc(12200.0),
		us2osc(15300.0), us2osc(19800.0), us2osc(24400.0),
		us2osc(30500.0)};
endpackage

// file: core/opsq_osc_timer.sv
// opsq_osc_timer: down counter that advances on oscillator ticks only.
// assumes tick is a one-cycle pulse already synchronised to clk.
`timescale 1ns/100ps
module opsq_osc_timer #(
	parameter int CW = 26
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// control
	input wire logic load,
	input wire logic [CW-1:0] loadValue,
	input wire logic tick,
	// status
	output logic done
);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic fresh;
	} opsq_tmr_t;
	opsq_tmr_t st_q;
	opsq_tmr_t st_d;

	always_comb
	begin
		st_d = st_q;
		st_d.fresh = 1'b0;
		if (load)
		begin
			st_d.cnt = loadValue;
			st_d.fresh = 1'b1;
		end
		else if (tick && st_q.cnt != '0)
			st_d.cnt = st_q.cnt - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// fresh holds done low in the cycle after a load, even when zero is loaded
	assign done = (st_q.cnt == '0) && !st_q.fresh;

	a_osc_only: assert property (
		@(posedge clk) disable iff (srst)
		!tick && !load |=> $stable(st_q.cnt))
		else $error("timer moved without an oscillator tick");
endmodule // opsq_osc_timer

// file: core/opsq_sequencer.sv
// opsq_sequencer: page-1 speaker control registers and the class-D
// speaker power sequence, with DAC power-down ordering.
// assumes a byte register port driven from clk, pins from other domains.
`timescale 1ns/100ps
module opsq_sequencer #(
	parameter int GAIN_STEPS = 8,
	parameter int unsigned TIME_SHIFT = 0
) (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// register port
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	output logic regRdValid,
	// pins from other domains
	input wire logic oscClkPin,
	input wire logic speakerShortPin,
	// power-down context
	input wire logic swPowerDown,
	input wire logic headphoneAmpsOff,
	// driver controls
	output logic speakerAmpPowered,
	output logic [$clog2(GAIN_STEPS+1)-1:0] speakerAmpGain,
	output logic speakerAmpReady,
	output logic dacPowerDown,
	output logic cmDividerEn
);
	localparam int GW = $clog2(GAIN_STEPS + 1);
	localparam logic [GW-1:0] GAIN_MAX = GW'(GAIN_STEPS);

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_PWRON = 6'h02,
		ST_RAMP = 6'h04,
		ST_WAIT = 6'h08,
		ST_ON = 6'h10,
		ST_RAMPDN = 6'h20
	} opsq_state_t;

	typedef struct packed {
		logic [7:0] page;
		logic [7:0] spk;
		logic [7:0] pop;
		logic [7:0] ramp;
		logic [2:0] oscSync;
		logic [2:0] shortSync;
		logic oscLevel;
		logic shortLevel;
		opsq_state_t state;
		logic [GW-1:0] gain;
		logic powered;
		logic ready;
		logic dacOff;
		logic cmDiv;
		logic [7:0] rdData;
		logic rdValid;
	} opsq_seq_t;

	opsq_seq_t st_q;
	opsq_seq_t st_d;
	logic oscTick;
	logic tmrLoad;
	logic [opsq_pkg::CW-1:0] tmrValue;
	logic tmrDone;
	logic pageOne;
	logic [3:0] pwronCode;
	logic [1:0] stepCode;
	logic [2:0] waitCode;
	logic shortLive;

	opsq_osc_timer #(.CW(opsq_pkg::CW)) u_timer (
		.clk(clk),
		.srst(srst),
		.load(tmrLoad),
		.loadValue(tmrValue),
		.tick(oscTick),
		.done(tmrDone)
	);

	assign pwronCode = st_q.pop[opsq_pkg::POP_PWRON_LSB +: 4];
	assign stepCode = st_q.pop[opsq_pkg::POP_STEP_LSB +: 2];
	assign waitCode = st_q.ramp[opsq_pkg::RAMP_WAIT_LSB +: 3];
	assign pageOne = (st_q.page == opsq_pkg::PAGE_ONE);
	assign shortLive = st_q.shortLevel && st_q.powered;
	assign oscTick = (st_q.oscSync[2] == st_q.oscSync[1])
		&& st_q.oscSync[1] && !st_q.oscLevel;

	always_comb
	begin
		st_d = st_q;
		tmrLoad = 1'b0;
		tmrValue = '0;
		st_d.rdValid = 1'b0;
		// three-stage sync; a change counts once stages 2 and 3 agree
		st_d.oscSync = {st_q.oscSync[1:0], oscClkPin};
		st_d.shortSync = {st_q.shortSync[1:0], speakerShortPin};
		if (st_q.oscSync[2] == st_q.oscSync[1])
			st_d.oscLevel = st_q.oscSync[1];
		if (st_q.shortSync[2] == st_q.shortSync[1])
			st_d.shortLevel = st_q.shortSync[1];

		// register writes; reserved bits are stored as written
		if (regWrEn)
		begin
			if (regAddr == opsq_pkg::ADDR_PAGE)
				st_d.page = regWrData;
			else if (pageOne)
			begin
				case (regAddr)
					opsq_pkg::ADDR_SPK:
						st_d.spk = {regWrData[7:1], 1'b0};
					opsq_pkg::ADDR_POP:
						st_d.pop = regWrData;
					opsq_pkg::ADDR_RAMP:
						st_d.ramp = regWrData;
					default:
						st_d.page = st_q.page;
				endcase
			end
		end

		// register reads, answered next cycle; unmapped reads as zero
		if (regRdEn)
		begin
			st_d.rdValid = 1'b1;
			st_d.rdData = 8'h00;
			if (regAddr == opsq_pkg::ADDR_PAGE)
				st_d.rdData = st_q.page;
			else if (pageOne)
			begin
				case (regAddr)
					opsq_pkg::ADDR_SPK:
						st_d.rdData = {st_q.spk[7:1], shortLive};
					opsq_pkg::ADDR_POP:
						st_d.rdData = st_q.pop;
					opsq_pkg::ADDR_RAMP:
						st_d.rdData = st_q.ramp;
					default:
						st_d.rdData = 8'h00;
				endcase
			end
		end

		case (st_q.state)
			ST_IDLE:
			begin
				st_d.gain = '0;
				if (st_q.spk[opsq_pkg::SPK_EN_BIT])
				begin
					st_d.powered = 1'b1;
					st_d.state = ST_PWRON;
					tmrLoad = 1'b1;
					tmrValue = opsq_pkg::PWRON_CYC[pwronCode] >> TIME_SHIFT;
				end
			end
			ST_PWRON:
			begin
				if (tmrDone)
				begin
					st_d.state = ST_RAMP;
					tmrLoad = 1'b1;
					tmrValue = opsq_pkg::STEP_CYC[stepCode] >> TIME_SHIFT;
				end
			end
			ST_RAMP:
			begin
				if (tmrDone)
				begin
					tmrLoad = 1'b1;
					if (st_q.gain == GAIN_MAX)
					begin
						st_d.state = ST_WAIT;
						tmrValue = opsq_pkg::WAIT_CYC[waitCode] >> TIME_SHIFT;
					end
					else
					begin
						st_d.gain = st_q.gain + 1'b1;
						tmrValue = opsq_pkg::STEP_CYC[stepCode] >> TIME_SHIFT;
					end
				end
			end
			ST_WAIT:
			begin
				if (tmrDone)
				begin
					st_d.state = ST_ON;
					st_d.ready = 1'b1;
				end
			end
			ST_ON:
				st_d.ready = 1'b1;
			ST_RAMPDN:
			begin
				// a re-enable waits until the ramp-down has finished
				if (tmrDone)
				begin
					if (st_q.gain == '0)
					begin
						st_d.state = ST_IDLE;
						st_d.powered = 1'b0;
					end
					else
					begin
						st_d.gain = st_q.gain - 1'b1;
						tmrLoad = 1'b1;
						tmrValue = opsq_pkg::STEP_CYC[stepCode] >> TIME_SHIFT;
					end
				end
			end
			default:
			begin
				st_d.state = ST_IDLE;
				st_d.powered = 1'b0;
				st_d.ready = 1'b0;
			end
		endcase

		if (!st_q.spk[opsq_pkg::SPK_EN_BIT] && st_q.state != ST_IDLE
			&& st_q.state != ST_RAMPDN)
		begin
			st_d.state = ST_RAMPDN;
			st_d.ready = 1'b0;
			tmrLoad = 1'b1;
			tmrValue = opsq_pkg::STEP_CYC[stepCode] >> TIME_SHIFT;
		end

		if (st_q.pop[opsq_pkg::POP_ORDER_BIT])
			st_d.dacOff = swPowerDown && headphoneAmpsOff && !st_q.powered;
		else
			st_d.dacOff = swPowerDown;

		// divider common-mode when bit is 0
		st_d.cmDiv = !st_q.pop[opsq_pkg::POP_CM_BIT];
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_q <= '0;
			st_q.page <= opsq_pkg::RST_PAGE;
			st_q.spk <= opsq_pkg::RST_SPK;
			st_q.pop <= opsq_pkg::RST_POP;
			st_q.ramp <= opsq_pkg::RST_RAMP;
			st_q.state <= ST_IDLE;
		end
		else
			st_q <= st_d;
	end

	assign regRdData = st_q.rdData;
	assign regRdValid = st_q.rdValid;
	assign speakerAmpPowered = st_q.powered;
	assign speakerAmpGain = st_q.gain;
	assign speakerAmpReady = st_q.ready;
	assign dacPowerDown = st_q.dacOff;
	assign cmDividerEn = st_q.cmDiv;

	sequence s_ramp_to_wait;
		st_q.state == ST_RAMP ##1 st_q.state == ST_WAIT;
	endsequence
	sequence s_wait_to_on;
		st_q.state == ST_WAIT ##1 st_q.state == ST_ON;
	endsequence

	a_enable_start: assert property (
		@(posedge clk) disable iff (srst)
		st_q.state == ST_IDLE && st_q.spk[opsq_pkg::SPK_EN_BIT]
		|=> st_q.state == ST_PWRON && speakerAmpPowered)
		else $error("enable did not start power-on");
	a_disable_ramp: assert property (
		@(posedge clk) disable iff (srst)
		st_q.state == ST_ON && !st_q.spk[opsq_pkg::SPK_EN_BIT]
		|=> st_q.state == ST_RAMPDN && !speakerAmpReady)
		else $error("disable did not start ramp-down");
	a_short_gated: assert property (
		@(posedge clk) disable iff (srst)
		regRdEn && pageOne && regAddr == opsq_pkg::ADDR_SPK
		&& !st_q.powered |=> regRdValid && !regRdData[0])
		else $error("short flag shown while unpowered");
	a_dac_together: assert property (
		@(posedge clk) disable iff (srst)
		!st_q.pop[opsq_pkg::POP_ORDER_BIT] && swPowerDown
		|=> dacPowerDown)
		else $error("dac not powered down with amps");
	a_dac_after: assert property (
		@(posedge clk) disable iff (srst)
		st_q.pop[opsq_pkg::POP_ORDER_BIT]
		&& (st_q.powered || !headphoneAmpsOff) |=> !dacPowerDown)
		else $error("dac powered down before amps off");
	// only the first edge after release; earlier edges see unreset state
	a_time_reset: assert property (
		@(posedge clk)
		$past(srst) && !srst |-> pwronCode == 4'h7 && waitCode == 3'h0)
		else $error("power-on or wait field reset wrong");
	a_step_reset: assert property (
		@(posedge clk)
		$past(srst) && !srst |-> stepCode == 2'h3)
		else $error("step field reset wrong");
	a_cm_divider: assert property (
		@(posedge clk) disable iff (srst)
		!st_q.pop[opsq_pkg::POP_CM_BIT] ##1 !st_q.pop[opsq_pkg::POP_CM_BIT]
		|-> cmDividerEn)
		else $error("divider common-mode not enabled");
	a_ramp_full: assert property (
		@(posedge clk) disable iff (srst)
		s_ramp_to_wait |-> speakerAmpGain == GAIN_MAX)
		else $error("wait entered before full gain");
	// ready rises with the on state; a disable right then goes to ramp-down instead of on
	a_ready_on: assert property (
		@(posedge clk) disable iff (srst)
		s_wait_to_on |-> speakerAmpReady)
		else $error("ready not raised after wait");
	a_wait_count: assert property (
		@(posedge clk) disable iff (srst)
		st_q.state == ST_WAIT && !tmrDone
		|=> st_q.state == ST_WAIT || st_q.state == ST_RAMPDN)
		else $error("wait left before time elapsed");
endmodule // opsq_sequencer

// file: verification/testbench.sv
// testbench: self-checking bench for the speaker power sequencer.
// assumes opsq_sequencer with oscillator counts shortened by TIME_SHIFT.
`timescale 1ns/100ps
module testbench;
	localparam int SHIFT = 12;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] regRdData;
	logic regRdValid;
	logic oscClkPin = 1'b0;
	logic speakerShortPin = 1'b0;
	logic swPowerDown = 1'b0;
	logic headphoneAmpsOff = 1'b0;
	logic speakerAmpPowered;
	logic [3:0] speakerAmpGain;
	logic speakerAmpReady;
	logic dacPowerDown;
	logic cmDividerEn;
	logic [7:0] expQ[$];
	int nErrors = 0;
	int checked = 0;
	int pc[4] = '{0, 7, 11, 0};
	real pu[4] = '{0.0, 304000.0, 6100000.0, 0.0};
	int sc[4] = '{0, 2, 1, 3};
	real su[4] = '{0.0, 1950.0, 980.0, 3900.0};
	int wc[4] = '{0, 7, 1, 4};
	real wu[4] = '{0.0, 30500.0, 3040.0, 15300.0};

	always #12.5 clk = ~clk;
	// oscillator period of exactly 4 clk, offset from clk edges
	initial
	begin
		#3;
		forever #50 oscClkPin = ~oscClkPin;
	end

	opsq_sequencer #(.GAIN_STEPS(8), .TIME_SHIFT(SHIFT)) opsq_sequencer_i (
		.clk(clk), .srst(srst), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.regRdValid(regRdValid), .oscClkPin(oscClkPin),
		.speakerShortPin(speakerShortPin), .swPowerDown(swPowerDown),
		.headphoneAmpsOff(headphoneAmpsOff),
		.speakerAmpPowered(speakerAmpPowered),
		.speakerAmpGain(speakerAmpGain), .speakerAmpReady(speakerAmpReady),
		.dacPowerDown(dacPowerDown), .cmDividerEn(cmDividerEn));

	function automatic int tk(input real us);
		return int'(us * 8.2) >>> SHIFT;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("errors=%0d checks=%0d", nErrors, checked);
		if (nErrors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge clk);
		regWrEn = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		expQ.push_back(e);
		@(negedge clk);
		regRdEn = 1'b1;
		regAddr = a;
		@(negedge clk);
		regRdEn = 1'b0;
	endtask

	task automatic inrange(input int t, input int lo, input int hi);
		check(32'(t >= lo && t <= hi), 32'h1);
	endtask

	// read results land one cycle after the strobe
	always @(negedge clk)
		if (regRdValid === 1'b1)
		begin
			if (expQ.size() > 0)
				check(32'(regRdData), 32'(expQ.pop_front()));
			else
				check(32'h1, 32'h0);
		end

	initial
	begin
		repeat (90000) @(posedge clk);
		nErrors++;
		give_verdict;
	end

	initial
	begin
		int t;
		int s;
		int w;
		logic o;
		void'($urandom(72));
		repeat (5) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
		check(32'(cmDividerEn), 32'h1);
		check(32'(speakerAmpPowered), 32'h0);
		rd(8'h20, 8'h00);
		wr(8'h00, 8'h02);
		rd(8'h00, 8'h02);
		rd(8'h21, 8'h00);
		wr(8'h00, 8'h01);
		rd(8'h20, 8'h06);
		rd(8'h21, 8'h3e);
		rd(8'h22, 8'h00);
		rd(8'h23, 8'h00);
		wr(8'h20, 8'h07);
		rd(8'h20, 8'h06);
		// reserved fields only ever get their reset values
		for (int i = 0; i < 4; i++)
		begin
			s = tk(su[i]);
			w = tk(wu[i]);
			wr(8'h21, 8'((pc[i] << 3) | (sc[i] << 1)));
			wr(8'h22, 8'(wc[i] << 4));
			wr(8'h20, 8'h86);
			// powered follows one edge after the write lands
			@(negedge clk);
			check(32'(speakerAmpPowered), 32'h1);
			t = 0;
			while (speakerAmpGain === 4'h0 && t < 60000)
			begin
				@(negedge clk);
				t++;
			end
			inrange(t, (tk(pu[i]) + s) * 4 - 4, (tk(pu[i]) + s) * 4 + 10);
			t = 0;
			while (speakerAmpGain === 4'h1 && t < 9000)
			begin
				@(negedge clk);
				t++;
			end
			inrange(t, s * 4 - 4, s * 4 + 4);
			while (speakerAmpGain !== 4'h8 && t < 9000)
			begin
				@(negedge clk);
				t++;
			end
			t = 0;
			while (speakerAmpReady !== 1'b1 && t < 9000)
			begin
				@(negedge clk);
				t++;
			end
			inrange(t, (s + w) * 4 - 4, (s + w) * 4 + 10);
			check(32'(speakerAmpGain), 32'h8);
			speakerShortPin = 1'b1;
			repeat (6) @(negedge clk);
			rd(8'h20, 8'h87);
			speakerShortPin = 1'b0;
			repeat (6) @(negedge clk);
			rd(8'h20, 8'h86);
			wr(8'h20, 8'h06);
			@(negedge clk);
			check(32'(speakerAmpReady), 32'h0);
			t = 0;
			while (speakerAmpPowered !== 1'b0 && t < 9000)
			begin
				@(negedge clk);
				t++;
			end
			check(32'(speakerAmpGain), 32'h0);
		end
		speakerShortPin = 1'b1;
		repeat (6) @(negedge clk);
		rd(8'h20, 8'h06);
		speakerShortPin = 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			o = 1'($urandom());
			wr(8'h21, {o, 7'h3e});
			swPowerDown = 1'($urandom());
			headphoneAmpsOff = 1'($urandom());
			repeat (2) @(negedge clk);
			check(32'(dacPowerDown), 32'(o ? swPowerDown && headphoneAmpsOff : swPowerDown));
		end
		wr(8'h21, 8'hbe);
		swPowerDown = 1'b1;
		headphoneAmpsOff = 1'b1;
		wr(8'h20, 8'h86);
		repeat (2) @(negedge clk);
		check(32'(dacPowerDown), 32'h0);
		repeat (4) @(negedge clk);
		check(32'(expQ.size()), 32'h0);
		give_verdict;
	end
endmodule // testbench
